// *** rtl/instruction_core.sv ***
/*
 * 8-bit accumulator core: four-clock instruction cycle, program and data memory ports.
 * Assumes both memories answer a held address within one ref_clk, on the same clock.
 */
// Summary of operation
// - Every instruction cycle lasts exactly four clock periods.
// - Ordinary instructions finish in one instruction cycle.
// - Jump, call, return, return-from-interrupt and table read take two cycles.
// - Writing the program counter low byte adds one cycle.
// - A taken skip adds one cycle; an untaken skip takes one.
// - Moves: memory to accumulator, accumulator to memory, immediate to accumulator.
// - Addition above 255 sets carry; subtraction below zero sets borrow.
// - Increment and decrement change by one, into memory or accumulator.
// - Logic operations and complement set zero flag when result is zero.
// - Rotates shift one bit; through-carry forms move the shifted bit to carry.
// - Return resumes at the address right after the call.
// - Jump loads the target and saves no return point.
// - Conditional skips test a byte or bit and skip the next instruction.
// - Bit set and clear change only the addressed bit, read-modify-write inside.
`timescale 1ns/1ps
module instruction_core
    import core_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Program memory
    output logic [PC_W-1:0]  pm_addr,
    input  wire logic [15:0] pm_rdata,
    // Data memory
    output logic [7:0]       dm_addr,
    output logic [7:0]       dm_wdata,
    output logic             dm_we,
    input  wire logic [7:0]  dm_rdata,
    // Status
    output logic [7:0]       acc,
    output logic             carry_flag,
    output logic             zero_flag,
    output logic             retire
);

    typedef struct packed {
        phase_e          ph;
        logic            dummy;
        logic            tbl;
        logic [PC_W-1:0] pc;
        logic [15:0]     ir;
        logic [7:0]      acc;
        logic            c;
        logic            z;
        logic [PC_W-1:0] pm_addr;
        logic [7:0]      dm_addr;
        logic [7:0]      dm_wdata;
        logic            dm_we;
        logic            push;
        logic            pop;
        logic [PC_W-1:0] push_data;
        logic            retire;
    } core_s;

    core_s s_q;
    core_s s_d;

    stack_if st ();

    return_stack #(.DEPTH(STACK_DEPTH)) u_stack
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .port    (st.stack)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [3:0]      op;
        logic [3:0]      sub;
        logic [7:0]      arg;
        logic [7:0]      opnd;
        logic [7:0]      rhs;
        logic [7:0]      res;
        logic [7:0]      mask;
        logic [8:0]      wide;
        logic            wr_a;
        logic            wr_m;
        logic            upd_z;
        logic            two;
        logic            skip;
        logic [PC_W-1:0] nxt;
        op    = s_q.ir[OP_HI:OP_LO];
        sub   = s_q.ir[SUB_HI:SUB_LO];
        arg   = s_q.ir[ARG_HI:0];
        // Reads of the counter low byte see the current instruction address
        opnd  = (arg == PCL_ADDR) ? s_q.pc[7:0] : dm_rdata;
        rhs   = (op == OP_ALU_X) ? arg : opnd;
        res   = 8'h00;
        mask  = 8'h01 << sub[2:0];
        wide  = 9'h000;
        wr_a  = 1'b0;
        wr_m  = 1'b0;
        upd_z = 1'b0;
        two   = 1'b0;
        skip  = 1'b0;
        nxt   = PC_W'(s_q.pc + 1'b1);

        s_d        = s_q;
        s_d.dm_we  = 1'b0;
        s_d.push   = 1'b0;
        s_d.pop    = 1'b0;
        s_d.retire = 1'b0;

        unique case (s_q.ph)
            PH_FETCH:
                s_d.ph = PH_LOAD;
            PH_LOAD:
            begin
                s_d.ph = PH_READ;
                if (s_q.dummy && s_q.tbl)
                begin
                    // Table word: high byte to accumulator, low byte to [m]
                    s_d.acc      = pm_rdata[15:8];
                    s_d.dm_wdata = pm_rdata[7:0];
                    s_d.dm_we    = (s_q.dm_addr != PCL_ADDR);
                    s_d.tbl      = 1'b0;
                end
                else if (!s_q.dummy)
                begin
                    s_d.ir      = pm_rdata;
                    s_d.dm_addr = pm_rdata[ARG_HI:0];
                end
            end
            PH_READ:
                s_d.ph = PH_EXEC;
            PH_EXEC:
            begin
                s_d.ph = PH_FETCH;
                if (s_q.dummy)
                begin
                    // Second cycle refetches; only a table read also moves data, in its load phase
                    s_d.dummy   = 1'b0;
                    s_d.pm_addr = s_q.pc;
                    s_d.retire  = 1'b1;
                end
                else
                begin
                    unique case (op)
                        OP_MOV_AM:
                        begin
                            res  = opnd;
                            wr_a = 1'b1;
                        end
                        OP_MOV_MA:
                        begin
                            res  = s_q.acc;
                            wr_m = 1'b1;
                        end
                        OP_MOV_AX:
                        begin
                            res  = arg;
                            wr_a = 1'b1;
                        end
                        OP_ALU_A, OP_ALU_M, OP_ALU_X:
                        begin
                            unique case (sub[2:0])
                                F_ADD: wide = {1'b0, s_q.acc} + {1'b0, rhs};
                                F_ADC: wide = {1'b0, s_q.acc} + {1'b0, rhs} + {8'h00, s_q.c};
                                F_SUB: wide = {1'b0, s_q.acc} - {1'b0, rhs};
                                F_SBC: wide = {1'b0, s_q.acc} - {1'b0, rhs} - {8'h00, s_q.c};
                                F_AND: wide = {1'b0, s_q.acc & rhs};
                                F_OR:  wide = {1'b0, s_q.acc | rhs};
                                F_XOR: wide = {1'b0, s_q.acc ^ rhs};
                                default: wide = {1'b0, s_q.acc};
                            endcase
                            res   = wide[7:0];
                            upd_z = 1'b1;
                            if (!sub[2])
                                s_d.c = wide[8];
                            wr_a  = (op != OP_ALU_M);
                            wr_m  = (op == OP_ALU_M);
                        end
                        OP_UN_A, OP_UN_M:
                        begin
                            unique case (sub[2:0])
                                U_INC:
                                begin
                                    res   = 8'(opnd + 8'h01);
                                    upd_z = 1'b1;
                                end
                                U_DEC:
                                begin
                                    res   = 8'(opnd - 8'h01);
                                    upd_z = 1'b1;
                                end
                                U_CPL:
                                begin
                                    res   = ~opnd;
                                    upd_z = 1'b1;
                                end
                                U_RR:  res = {opnd[0], opnd[7:1]};
                                U_RL:  res = {opnd[6:0], opnd[7]};
                                U_RRC:
                                begin
                                    res   = {s_q.c, opnd[7:1]};
                                    s_d.c = opnd[0];
                                end
                                U_RLC:
                                begin
                                    res   = {opnd[6:0], s_q.c};
                                    s_d.c = opnd[7];
                                end
                                U_CLR: res = 8'h00;
                            endcase
                            wr_a = (op == OP_UN_A);
                            wr_m = (op == OP_UN_M);
                        end
                        OP_BSET:
                        begin
                            res  = opnd | mask;
                            wr_m = 1'b1;
                        end
                        OP_BCLR:
                        begin
                            res  = opnd & ~mask;
                            wr_m = 1'b1;
                        end
                        OP_SK_BYTE:
                            skip = sub[0] ? (opnd != 8'h00) : (opnd == 8'h00);
                        OP_SK_BIT:
                            skip = sub[3] ? |(opnd & mask) : ~|(opnd & mask);
                        OP_JMP:
                        begin
                            nxt = s_q.ir[PC_W-1:0];
                            two = 1'b1;
                        end
                        OP_CALL:
                        begin
                            s_d.push      = 1'b1;
                            s_d.push_data = nxt;
                            nxt           = s_q.ir[PC_W-1:0];
                            two           = 1'b1;
                        end
                        OP_MISC:
                        begin
                            if (sub[1:0] == M_RET || sub[1:0] == M_RETURN_FROM_INTERRUPT)
                            begin
                                nxt     = st.rdata;
                                s_d.pop = 1'b1;
                                two     = 1'b1;
                            end
                            else if (sub[1:0] == M_TABRD)
                            begin
                                s_d.tbl = 1'b1;
                                two     = 1'b1;
                            end
                        end
                        OP_NOP: ;
                    endcase

                    if (skip)
                    begin
                        nxt = PC_W'(s_q.pc + 2'd2);
                        two = 1'b1;
                    end
                    if (wr_a)
                        s_d.acc = res;
                    if (upd_z)
                        s_d.z = (res == 8'h00);
                    if (wr_m && arg == PCL_ADDR)
                    begin
                        // Counter low byte is not in data memory; write jumps
                        nxt = {s_q.pc[PC_W-1:8], res};
                        two = 1'b1;
                    end
                    else if (wr_m)
                    begin
                        s_d.dm_wdata = res;
                        s_d.dm_we    = 1'b1;
                    end

                    s_d.pc      = nxt;
                    s_d.dummy   = two;
                    s_d.retire  = !two;
                    // Table read fetches its word during the spare cycle
                    s_d.pm_addr = (s_d.tbl) ? {s_q.pc[PC_W-1:8], s_q.acc} : nxt;
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q         <= '0;
            s_q.ph      <= PH_FETCH;
            s_q.pc      <= PC_RESET;
            s_q.pm_addr <= PC_RESET;
            s_q.acc     <= ACC_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign st.push    = s_q.push;
    assign st.pop     = s_q.pop;
    assign st.wdata   = s_q.push_data;
    assign pm_addr    = s_q.pm_addr;
    assign dm_addr    = s_q.dm_addr;
    assign dm_wdata   = s_q.dm_wdata;
    assign dm_we      = s_q.dm_we;
    assign acc        = s_q.acc;
    assign carry_flag = s_q.c;
    assign zero_flag  = s_q.z;
    assign retire     = s_q.retire;

endmodule // instruction_core

// *** rtl/core_pkg.sv ***
/*
 * Shared constants and types for the 8-bit instruction core and its return stack.
 * Assumes a 16-bit program word and an 8-bit data memory address space.
 */
package core_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int PC_W        = 12;
    localparam int STACK_DEPTH = 8;
    localparam int CLK_PER_CYC = 4;

    // ==========================================================
    // Instruction word layout
    localparam int OP_HI  = 15;
    localparam int OP_LO  = 12;
    localparam int SUB_HI = 11;
    localparam int SUB_LO = 8;
    localparam int ARG_HI = 7;

    // ==========================================================
    // Special data addresses and reset values
    localparam logic [7:0]      PCL_ADDR  = 8'h06;
    localparam logic [PC_W-1:0] PC_RESET  = 12'h000;
    localparam logic [7:0]      ACC_RESET = 8'h00;

    // ==========================================================
    // Opcodes (bits 15:12)
    localparam logic [3:0] OP_MOV_AM  = 4'h0;
    localparam logic [3:0] OP_MOV_MA  = 4'h1;
    localparam logic [3:0] OP_MOV_AX  = 4'h2;
    localparam logic [3:0] OP_ALU_A   = 4'h3;
    localparam logic [3:0] OP_ALU_M   = 4'h4;
    localparam logic [3:0] OP_ALU_X   = 4'h5;
    localparam logic [3:0] OP_UN_A    = 4'h6;
    localparam logic [3:0] OP_UN_M    = 4'h7;
    localparam logic [3:0] OP_BSET    = 4'h8;
    localparam logic [3:0] OP_BCLR    = 4'h9;
    localparam logic [3:0] OP_SK_BYTE = 4'ha;
    localparam logic [3:0] OP_SK_BIT  = 4'hb;
    localparam logic [3:0] OP_JMP     = 4'hc;
    localparam logic [3:0] OP_CALL    = 4'hd;
    localparam logic [3:0] OP_MISC    = 4'he;
    localparam logic [3:0] OP_NOP     = 4'hf;

    // ==========================================================
    // Two-operand functions (bits 10:8)
    localparam logic [2:0] F_ADD = 3'h0;
    localparam logic [2:0] F_ADC = 3'h1;
    localparam logic [2:0] F_SUB = 3'h2;
    localparam logic [2:0] F_SBC = 3'h3;
    localparam logic [2:0] F_AND = 3'h4;
    localparam logic [2:0] F_OR  = 3'h5;
    localparam logic [2:0] F_XOR = 3'h6;

    // ==========================================================
    // One-operand functions (bits 10:8)
    localparam logic [2:0] U_INC = 3'h0;
    localparam logic [2:0] U_DEC = 3'h1;
    localparam logic [2:0] U_CPL = 3'h2;
    localparam logic [2:0] U_RR  = 3'h3;
    localparam logic [2:0] U_RL  = 3'h4;
    localparam logic [2:0] U_RRC = 3'h5;
    localparam logic [2:0] U_RLC = 3'h6;
    localparam logic [2:0] U_CLR = 3'h7;

    // ==========================================================
    // Miscellaneous functions (bits 9:8)
    localparam logic [1:0] M_RET   = 2'h0;
    localparam logic [1:0] M_RETURN_FROM_INTERRUPT  = 2'h1;
    localparam logic [1:0] M_TABRD = 2'h2;

    // ==========================================================
    // Phases of one instruction cycle
    typedef enum logic [1:0] {PH_FETCH, PH_LOAD, PH_READ, PH_EXEC} phase_e;

endpackage

// *** rtl/stack_if.sv ***
/*
 * Push/pop link between the instruction core and its return stack.
 * Assumes both ends share ref_clk; push and pop are one-clock pulses.
 */
`timescale 1ns/1ps
interface stack_if;
    import core_pkg::*;

    logic            push;
    logic            pop;
    logic [PC_W-1:0] wdata;
    logic [PC_W-1:0] rdata;

    modport core  (output push, output pop, output wdata, input rdata);
    modport stack (input push, input pop, input wdata, output rdata);

endinterface

// *** rtl/return_stack.sv ***
/*
 * Circular hardware return stack; top entry is presented from a register.
 * Assumes DEPTH is a power of two and push and pop never coincide.
 */
`timescale 1ns/1ps
module return_stack
    import core_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Core side
    stack_if.stack   port
);

    localparam int SP_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] mem;
        logic [SP_W-1:0]            sp;
        logic [PC_W-1:0]            top;
    } stack_s;

    stack_s s_q;
    stack_s s_d;

    // ==========================================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        if (port.push)
        begin
            s_d.mem[s_q.sp] = port.wdata;
            s_d.sp          = SP_W'(s_q.sp + 1'b1);
        end
        else if (port.pop)
        begin
            s_d.sp = SP_W'(s_q.sp - 1'b1);
        end
        // Overflow wraps and overwrites the oldest entry
        s_d.top = s_d.mem[SP_W'(s_d.sp - 1'b1)];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign port.rdata = s_q.top;

endmodule // return_stack

// *** verification/instruction_core_sva.sv ***
/*
 * Timing checker for the instruction core, bound to its ports.
 * Assumes one ref_clk domain and the asynchronous active-low resetn.
 */
`timescale 1ns/1ps
module instruction_core_sva
    import core_pkg::*;
(
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            resetn,
    // Memory side
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic [7:0]      dm_addr,
    input wire logic [7:0]      dm_wdata,
    input wire logic            dm_we,
    // Status
    input wire logic [7:0]      acc,
    input wire logic            carry_flag,
    input wire logic            zero_flag,
    input wire logic            retire
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_retire_min_gap: assert property (retire |=> !retire [*3])
        else $error("retire pulses closer than one instruction cycle");
    a_retire_max_gap: assert property (retire |-> ##[4:8] retire)
        else $error("next instruction took more than two cycles");
    a_fetch_addr_hold: assert property ($changed(pm_addr) |=> $stable(pm_addr) [*3])
        else $error("program address held for less than four clocks");
    a_data_addr_hold: assert property ($changed(dm_addr) |=> $stable(dm_addr) [*3])
        else $error("data address held for less than four clocks");
    a_write_one_clk: assert property (dm_we |=> !dm_we)
        else $error("write strobe longer than one clock");
    a_no_counter_write: assert property (dm_we |-> dm_addr != PCL_ADDR)
        else $error("program counter low byte written to data memory");
    a_write_near_retire: assert property (dm_we |-> (retire or ##3 retire))
        else $error("memory write not tied to an instruction end");
    a_write_addr_held: assert property (dm_we |=> $stable(dm_addr) && $stable(dm_wdata))
        else $error("write address or data moved under the strobe");
    a_flags_by_retire: assert property (
        ($changed(carry_flag) || $changed(zero_flag)) |-> ##[0:4] retire)
        else $error("flags changed away from an instruction end");
    a_acc_by_retire: assert property ($changed(acc) |-> ##[0:4] retire)
        else $error("accumulator changed away from an instruction end");
endmodule // instruction_core_sva

bind instruction_core instruction_core_sva i_instruction_core_sva (
    .ref_clk(ref_clk), .resetn(resetn), .pm_addr(pm_addr), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .acc(acc), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .retire(retire));

// *** verification/mem_model.sv ***
/*
 * Program and data memory facing the instruction core.
 * Assumes the bench preloads both arrays while the core is held in reset.
 */
`timescale 1ns/1ps
module mem_model
    import core_pkg::*;
(
    // Clock
    input wire logic            ref_clk,
    // Program memory
    input wire logic [PC_W-1:0] pm_addr,
    output logic [15:0]         pm_rdata,
    // Data memory
    input wire logic [7:0]      dm_addr,
    input wire logic [7:0]      dm_wdata,
    input wire logic            dm_we,
    output logic [7:0]          dm_rdata
);
    logic [15:0] prog [0:(1<<PC_W)-1];
    logic [7:0]  data [0:255];

    // ==========================================================
    // Fetch is combinational; data read is registered, the slowest the core allows
    assign pm_rdata = prog[pm_addr];

    always @(posedge ref_clk)
    begin
        if (dm_we)
        begin
            data[dm_addr] <= dm_wdata;
        end
        dm_rdata <= data[dm_addr];
    end
endmodule // mem_model

// *** verification/tb.sv ***
/*
 * Self-checking bench: short programs per scenario, judged at every retire.
 * Assumes mem_model as both memories and the bound timing checker.
 */
`timescale 1ns/1ps
module tb;
    import core_pkg::*;

    logic            ref_clk;
    logic            resetn;
    logic [PC_W-1:0] pm_addr;
    logic [15:0]     pm_rdata;
    logic [7:0]      dm_addr;
    logic [7:0]      dm_wdata;
    logic            dm_we;
    logic [7:0]      dm_rdata;
    logic [7:0]      acc;
    logic            carry_flag;
    logic            zero_flag;
    logic            retire;
    int              miscompares;
    int              comparisons;
    logic [7:0]      e_acc [$];
    logic [1:0]      e_cz [$];
    int              e_gap [$];

    instruction_core i_instruction_core (.ref_clk(ref_clk), .resetn(resetn),
        .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .dm_we(dm_we), .dm_rdata(dm_rdata), .acc(acc), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .retire(retire));
    mem_model i_mem_model (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));

    always #50 ref_clk = ~ref_clk;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] w(logic [3:0] op, logic [3:0] sub, logic [7:0] arg);
        return {op, sub, arg};
    endfunction

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Unused program space holds a visible marker so a wrong branch shows in acc
    task automatic start();
        @(negedge ref_clk);
        resetn = 1'b0;
        for (int i = 0; i < (1 << PC_W); i++)
            i_mem_model.prog[i] = 16'h20ee;
        for (int i = 0; i < 256; i++)
            i_mem_model.data[i] = 8'h00;
        e_acc.delete();
        e_cz.delete();
        e_gap.delete();
    endtask

    // Gap of 0 leaves the clock count unchecked
    task automatic ins(logic [PC_W-1:0] a, logic [15:0] d, logic [7:0] v, logic [1:0] cz, int g);
        i_mem_model.prog[a] = d;
        e_acc.push_back(v);
        e_cz.push_back(cz);
        e_gap.push_back(g);
    endtask

    task automatic run();
        int gap;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        foreach (e_acc[k])
        begin
            gap = 0;
            do
            begin
                @(negedge ref_clk);
                gap++;
            end while (retire !== 1'b1 && gap < 20);
            check("retire", {15'h0, retire}, 16'h0001);
            check("acc", {8'h00, acc}, {8'h00, e_acc[k]});
            check("flags", {14'h0, carry_flag, zero_flag}, {14'h0, e_cz[k]});
            if (e_gap[k] != 0)
                check("clocks", gap[15:0], e_gap[k][15:0]);
        end
        repeat (2) @(negedge ref_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_arith();
        start();
        i_mem_model.data[8'h41] = 8'hff;
        i_mem_model.data[8'h42] = 8'h01;
        ins(12'h000, w(OP_MOV_AX, 4'h0, 8'hf0), 8'hf0, 2'b00, 0);
        ins(12'h001, w(OP_ALU_X, {1'b0, F_ADD}, 8'h20), 8'h10, 2'b10, 4);
        ins(12'h002, w(OP_MOV_MA, 4'h0, 8'h40), 8'h10, 2'b10, 4);
        ins(12'h003, w(OP_ALU_X, {1'b0, F_SUB}, 8'h11), 8'hff, 2'b10, 4);
        ins(12'h004, w(OP_MOV_AM, 4'h0, 8'h40), 8'h10, 2'b10, 4);
        ins(12'h005, w(OP_UN_A, {1'b0, U_INC}, 8'h41), 8'h00, 2'b11, 4);
        ins(12'h006, w(OP_UN_M, {1'b0, U_DEC}, 8'h42), 8'h00, 2'b11, 4);
        ins(12'h007, w(OP_ALU_X, {1'b0, F_ADD}, 8'h01), 8'h01, 2'b00, 4);
        ins(12'h008, w(OP_ALU_X, {1'b0, F_ADC}, 8'hff), 8'h00, 2'b11, 4);
        ins(12'h009, w(OP_ALU_X, {1'b0, F_SBC}, 8'h00), 8'hff, 2'b10, 4);
        ins(12'h00a, w(OP_ALU_X, {1'b0, F_XOR}, 8'hff), 8'h00, 2'b11, 4);
        run();
        check("mem40", {8'h00, i_mem_model.data[8'h40]}, 16'h0010);
        check("mem42", {8'h00, i_mem_model.data[8'h42]}, 16'h0000);
        $display("test arith done");
    endtask

    task automatic test_logic();
        start();
        i_mem_model.data[8'h50] = 8'h81;
        i_mem_model.data[8'h51] = 8'hff;
        i_mem_model.data[8'h53] = 8'h5a;
        i_mem_model.data[8'h54] = 8'ha5;
        ins(12'h000, w(OP_MOV_AX, 4'h0, 8'h81), 8'h81, 2'b00, 0);
        ins(12'h001, w(OP_UN_A, {1'b0, U_RLC}, 8'h50), 8'h02, 2'b10, 4);
        ins(12'h002, w(OP_UN_A, {1'b0, U_RRC}, 8'h50), 8'hc0, 2'b10, 4);
        ins(12'h003, w(OP_UN_A, {1'b0, U_RR}, 8'h50), 8'hc0, 2'b10, 4);
        ins(12'h004, w(OP_UN_A, {1'b0, U_RL}, 8'h50), 8'h03, 2'b10, 4);
        ins(12'h005, w(OP_UN_A, {1'b0, U_CPL}, 8'h51), 8'h00, 2'b11, 4);
        ins(12'h006, w(OP_ALU_M - 4'h1, {1'b0, F_OR}, 8'h53), 8'h5a, 2'b10, 4);
        ins(12'h007, w(OP_ALU_M, {1'b0, F_AND}, 8'h54), 8'h5a, 2'b11, 4);
        run();
        check("mem54", {8'h00, i_mem_model.data[8'h54]}, 16'h0000);
        $display("test logic done");
    endtask

    task automatic test_skip();
        start();
        i_mem_model.data[8'h60] = 8'h55;
        ins(12'h000, w(OP_BSET, 4'h1, 8'h60), 8'h00, 2'b00, 0);
        ins(12'h001, w(OP_BCLR, 4'h0, 8'h60), 8'h00, 2'b00, 4);
        ins(12'h002, w(OP_SK_BIT, 4'h9, 8'h60), 8'h00, 2'b00, 8);
        i_mem_model.prog[3] = w(OP_MOV_AX, 4'h0, 8'hee);
        ins(12'h004, w(OP_SK_BIT, 4'h1, 8'h60), 8'h00, 2'b00, 4);
        ins(12'h005, w(OP_MOV_AX, 4'h0, 8'h11), 8'h11, 2'b00, 4);
        ins(12'h006, w(OP_SK_BYTE, 4'h0, 8'h61), 8'h11, 2'b00, 8);
        ins(12'h008, w(OP_SK_BYTE, 4'h1, 8'h61), 8'h11, 2'b00, 4);
        ins(12'h009, w(OP_MOV_AX, 4'h0, 8'h22), 8'h22, 2'b00, 4);
        run();
        check("mem60", {8'h00, i_mem_model.data[8'h60]}, 16'h0056);
        $display("test skip done");
    endtask

    task automatic test_flow();
        start();
        i_mem_model.prog[7] = 16'habcd;
        ins(12'h000, w(OP_CALL, 4'h0, 8'h10), 8'h00, 2'b00, 0);
        ins(12'h010, w(OP_MOV_AX, 4'h0, 8'h07), 8'h07, 2'b00, 4);
        ins(12'h011, w(OP_MISC, {2'b00, M_TABRD}, 8'h70), 8'hab, 2'b00, 8);
        ins(12'h012, w(OP_MISC, {2'b00, M_RET}, 8'h00), 8'hab, 2'b00, 8);
        ins(12'h001, w(OP_JMP, 4'h0, 8'h20), 8'hab, 2'b00, 8);
        ins(12'h020, w(OP_MOV_AX, 4'h0, 8'h30), 8'h30, 2'b00, 4);
        ins(12'h021, w(OP_MOV_MA, 4'h0, PCL_ADDR), 8'h30, 2'b00, 8);
        ins(12'h030, w(OP_MOV_AX, 4'h0, 8'h44), 8'h44, 2'b00, 4);
        ins(12'h031, w(OP_CALL, 4'h0, 8'h40), 8'h44, 2'b00, 8);
        ins(12'h040, w(OP_MISC, {2'b00, M_RETURN_FROM_INTERRUPT}, 8'h00), 8'h44, 2'b00, 8);
        ins(12'h032, w(OP_MOV_AX, 4'h0, 8'h55), 8'h55, 2'b00, 4);
        run();
        check("mem70", {8'h00, i_mem_model.data[8'h70]}, 16'h00cd);
        check("mem06", {8'h00, i_mem_model.data[PCL_ADDR]}, 16'h0000);
        $display("test flow done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        miscompares = 0;
        comparisons = 0;
        test_arith();
        test_logic();
        test_skip();
        test_flow();
        end_sim();
    end

    // Four short programs need well under a thousand clocks
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_sim();
    end
endmodule // tb
